//--- design/scdw_pkg.sv
package scdw_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned TICK_NS       = 1000;  // timer time base
  localparam int unsigned TICK_CYCLES   =
    (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TRACK_NS      = 2000;  // auto peak-follow length
  localparam int unsigned TRACK_CYCLES  =
    (TRACK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_NS       = 1000;  // wake-up low pulse
  localparam int unsigned WAKE_CYCLES   =
    (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_LAG      = 4;     // line turnaround guard

  // ************************************************************
  // commands
  // ************************************************************
  localparam logic [3:0] CMD_NOP    = 4'h0;
  localparam logic [3:0] CMD_WRITE  = 4'h1;
  localparam logic [3:0] CMD_READ   = 4'h2;
  localparam logic [3:0] CMD_MRESET = 4'h3;

  // ************************************************************
  // register offsets and reset values
  // ************************************************************
  localparam int unsigned REG_COUNT    = 11;
  localparam logic [3:0]  REG_POWER    = 4'h0;
  localparam logic [3:0]  REG_CONFIG   = 4'h1;
  localparam logic [3:0]  REG_CONTROL  = 4'h2;
  localparam logic [3:0]  REG_XTAL_DIV = 4'h3;
  localparam logic [3:0]  REG_OFF_HI   = 4'h4;
  localparam logic [3:0]  REG_OFF_LO   = 4'h5;
  localparam logic [3:0]  REG_HOST_REC = 4'h6;
  localparam logic [3:0]  REG_RF_HI    = 4'h7;
  localparam logic [3:0]  REG_RF_LO    = 4'h8;
  localparam logic [3:0]  REG_STATUS   = 4'h9;
  localparam logic [3:0]  REG_DWELL    = 4'ha;
  localparam logic [7:0]  RST_ZERO     = 8'h00;
  localparam logic [7:0]  RST_DWELL    = 8'h0d;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int unsigned PWR_SLEEP_BIT    = 0;
  localparam int unsigned PWR_FREQ_PD_BIT  = 2;
  localparam int unsigned PWR_AMP_PD_BIT   = 3;
  localparam int unsigned CFG_DRX_BIT      = 2;
  localparam int unsigned CFG_FREQ_SEL_BIT = 6;
  localparam int unsigned CFG_AMP_SEL_BIT  = 7;
  localparam int unsigned CTL_TRACK_BIT    = 1;
  localparam int unsigned STAT_TRACK_BIT   = 0;
  localparam int unsigned STAT_ACTIVE_BIT  = 1;
  localparam int unsigned STAT_ACK_BIT     = 2;

  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [7:0] data;
  } scdw_frame_s;

  typedef enum logic [4:0] {
    DRX_IDLE   = 5'b00001,
    DRX_OFF    = 5'b00010,
    DRX_HOST   = 5'b00100,
    DRX_SETTLE = 5'b01000,
    DRX_ACTIVE = 5'b10000
  } scdw_drx_e;

endpackage : scdw_pkg

//--- design/scdw_serial_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module scdw_serial_ctrl
  import scdw_pkg::*;
(
  input  wire logic       CORE_CLK_I,
  input  wire logic       SYS_RST_I,
  input  wire logic       SCLK_I,
  input  wire logic       CS_N_I,
  input  wire logic       SERIAL_LINE_I,
  output var  logic       SERIAL_LINE_O,
  output var  logic       SERIAL_LINE_OE_O,
  output var  logic       SERIAL_LINE_PU_O,
  input  wire logic       FREQ_SLICER_I,
  input  wire logic       AMP_SLICER_I,
  input  wire logic       AGC_SWITCH_I,
  output var  logic       FREQ_DEMOD_OUTPUT_O,
  output var  logic       AMP_DEMOD_OUTPUT_O,
  output var  logic       PEAK_FOLLOW_O,
  output var  logic       DEEP_SLEEP_O,
  output var  logic [7:0] POWER_EN_O,
  output var  logic [7:0] CRYSTAL_DIVISOR_O
);

  // ************************************************************
  // input synchronisation and edges
  // ************************************************************
  logic [4:0]  sync_w;
  logic        sclk_s;
  logic        cs_n_s;
  logic        line_s;
  logic        freq_s;
  logic        amp_s;
  logic        sclk_prev_q;
  logic        cs_prev_q;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_fall;
  logic        cs_rise;

  scdw_sync #(
    .WIDTH (5)
  ) u_sync (
    .clk_i   (CORE_CLK_I),
    .rst_i   (SYS_RST_I),
    .async_i ({SCLK_I, CS_N_I, SERIAL_LINE_I, FREQ_SLICER_I, AMP_SLICER_I}),
    .sync_o  (sync_w)
  );

  assign {sclk_s, cs_n_s, line_s, freq_s, amp_s} = sync_w;

  // previous samples for edge finding
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
    end
    else
    begin
      sclk_prev_q <= sclk_s;
      cs_prev_q   <= cs_n_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_prev_q & ~cs_n_s;
  assign cs_fall   = ~cs_n_s & cs_prev_q;
  assign cs_rise   = cs_n_s & ~cs_prev_q;

  // ************************************************************
  // register file
  // ************************************************************
  logic [7:0]  regs_q [REG_COUNT];
  logic [7:0]  status;
  logic        mreset_q;
  logic        wr_fire;
  scdw_frame_s frame;
  logic        four_wire;
  logic        drx_en;
  logic        sleep_bit;

  localparam logic [REG_COUNT-1:0][7:0] REG_RESET = {
    RST_DWELL, {(REG_COUNT-1){RST_ZERO}}
  };

  // one write port per register except status; master reset acts like power-up
  for (genvar g = 0; g < REG_COUNT; g++)
  begin : g_reg
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
    begin
      if (SYS_RST_I)
        regs_q[g] <= REG_RESET[g];
      else if (mreset_q)
        regs_q[g] <= REG_RESET[g];
      else if (wr_fire && frame.addr == 4'(g) && 4'(g) != REG_STATUS)
        regs_q[g] <= frame.data;
    end
  end

  assign four_wire = regs_q[REG_CONFIG][CFG_FREQ_SEL_BIT]
                   | regs_q[REG_CONFIG][CFG_AMP_SEL_BIT];
  assign drx_en    = regs_q[REG_CONFIG][CFG_DRX_BIT];
  assign sleep_bit = regs_q[REG_POWER][PWR_SLEEP_BIT];

  // register read mux, status composed live
  function automatic logic [7:0] reg_value(input logic [3:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == REG_STATUS)
      v = status;
    else if (32'(a) < REG_COUNT)
      v = regs_q[a];
    return v;
  endfunction : reg_value

  // ************************************************************
  // frame receiver and read shifter
  // ************************************************************
  logic [4:0]  bit_cnt_q;
  logic [15:0] shift_q;
  logic [7:0]  head;
  logic [3:0]  nibble;
  logic        mrst_arm_q;
  logic        read_pend_q;
  logic        rd3_q;
  logic        rd4_q;
  logic [7:0]  out_sh_q;
  logic        skip_q;
  logic [7:0]  rd_data_q;

  assign frame   = scdw_frame_s'({shift_q[14:0], line_s});
  assign head    = {shift_q[6:0], line_s};
  assign nibble  = {shift_q[2:0], line_s};
  // no-op and unused codes never reach this strobe
  assign wr_fire = sclk_rise & ~rd3_q & (bit_cnt_q == 5'd15)
                 & (frame.cmd == CMD_WRITE);

  // command, address and data shift in msb first
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      bit_cnt_q   <= 5'd0;
      shift_q     <= 16'h0000;
      mrst_arm_q  <= 1'b0;
      read_pend_q <= 1'b0;
      rd3_q       <= 1'b0;
      rd4_q       <= 1'b0;
      out_sh_q    <= 8'h00;
      skip_q      <= 1'b0;
      rd_data_q   <= 8'h00;
    end
    else if (cs_fall)
    begin
      bit_cnt_q  <= 5'd0;
      mrst_arm_q <= 1'b0;
      if (read_pend_q && !four_wire)
      begin
        rd3_q    <= 1'b1;
        out_sh_q <= rd_data_q;
        skip_q   <= 1'b0;
      end
      read_pend_q <= 1'b0;
    end
    else if (cs_rise)
    begin
      rd3_q <= 1'b0;
      rd4_q <= 1'b0;
    end
    else if (sclk_rise && !rd3_q)
    begin
      shift_q <= {shift_q[14:0], line_s};
      if (bit_cnt_q != 5'd16)
        bit_cnt_q <= bit_cnt_q + 5'd1;
      if (bit_cnt_q == 5'd3 && nibble == CMD_MRESET)
        mrst_arm_q <= 1'b1;
      if (bit_cnt_q == 5'd7 && head[7:4] == CMD_READ)
      begin
        rd_data_q <= reg_value(head[3:0]);
        if (four_wire)
        begin
          rd4_q    <= 1'b1;
          out_sh_q <= reg_value(head[3:0]);
          skip_q   <= 1'b1;
        end
        else
          read_pend_q <= 1'b1;
      end
    end
    else if (sclk_fall && (rd3_q || rd4_q))
    begin
      if (skip_q)
        skip_q <= 1'b0;
      else
        out_sh_q <= {out_sh_q[6:0], 1'b0};
    end
  end

  // internal reset held while select stays high after the command
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
      mreset_q <= 1'b0;
    else if (cs_rise && mrst_arm_q)
      mreset_q <= 1'b1;
    else if (!cs_n_s)
      mreset_q <= 1'b0;
  end

  // ************************************************************
  // duty-cycled receive sequencer
  // ************************************************************
  scdw_drx_e   st_q;
  logic [9:0]  tick_q;
  logic [15:0] cnt_q;
  logic [9:0]  wake_q;
  logic        ack_q;
  logic        done;
  logic        wake_drive;
  logic [15:0] off_val;
  logic [15:0] host_val;
  logic [15:0] rf_val;

  assign done       = (cnt_q == 16'h0000);
  assign wake_drive = (st_q == DRX_HOST) && (32'(wake_q) > SYNC_LAG);
  assign off_val    = {regs_q[REG_OFF_HI], regs_q[REG_OFF_LO]};
  assign host_val   = {8'h00, regs_q[REG_HOST_REC]};
  assign rf_val     = {regs_q[REG_RF_HI], regs_q[REG_RF_LO]};

  // off, host-recovery and settle intervals in timer ticks
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      st_q   <= DRX_IDLE;
      tick_q <= 10'd0;
      cnt_q  <= 16'h0000;
      wake_q <= 10'd0;
      ack_q  <= 1'b0;
    end
    else
    begin
      if (tick_q == 10'd0)
      begin
        tick_q <= 10'(TICK_CYCLES - 1);
        if (!done)
          cnt_q <= cnt_q - 16'h0001;
      end
      else
        tick_q <= tick_q - 10'd1;
      if (wake_q != 10'd0)
        wake_q <= wake_q - 10'd1;
      if (!drx_en || !cs_n_s || mreset_q)
        st_q <= DRX_IDLE;
      else
      begin
        unique case (st_q)
          DRX_IDLE:
            if (line_s)
            begin
              st_q   <= DRX_OFF;
              cnt_q  <= off_val;
              tick_q <= 10'(TICK_CYCLES - 1);
            end
          DRX_OFF:
            if (done)
            begin
              st_q   <= DRX_HOST;
              cnt_q  <= host_val;
              tick_q <= 10'(TICK_CYCLES - 1);
              wake_q <= 10'(WAKE_CYCLES + SYNC_LAG);
              ack_q  <= 1'b0;
            end
          DRX_HOST:
          begin
            if (wake_q == 10'd0 && !line_s)
              ack_q <= 1'b1;
            if (done)
            begin
              st_q   <= DRX_SETTLE;
              cnt_q  <= rf_val;
              tick_q <= 10'(TICK_CYCLES - 1);
            end
          end
          DRX_SETTLE:
          begin
            if (!line_s)
              ack_q <= 1'b1;
            if (done)
            begin
              st_q   <= (ack_q || !line_s) ? DRX_ACTIVE : DRX_OFF;
              cnt_q  <= off_val;
              tick_q <= 10'(TICK_CYCLES - 1);
            end
          end
          DRX_ACTIVE:
            if (line_s)
            begin
              st_q   <= DRX_OFF;
              cnt_q  <= off_val;
              tick_q <= 10'(TICK_CYCLES - 1);
            end
        endcase
      end
    end
  end

  // ************************************************************
  // peak-follow control
  // ************************************************************
  logic [9:0] trk_q;
  logic       follow;

  // automatic pulse after wake-up and after each gain switch
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
      trk_q <= 10'd0;
    else if (AGC_SWITCH_I
             || (st_q == DRX_SETTLE && done && (ack_q || !line_s)
                 && drx_en && cs_n_s && !mreset_q))
      trk_q <= 10'(TRACK_CYCLES);
    else if (trk_q != 10'd0)
      trk_q <= trk_q - 10'd1;
  end

  assign follow = regs_q[REG_CONTROL][CTL_TRACK_BIT] | (trk_q != 10'd0);
  assign status = {5'h00, ack_q, st_q == DRX_ACTIVE, follow};

  // ************************************************************
  // registered outputs
  // ************************************************************
  logic demod_en;

  assign demod_en = !drx_en || st_q == DRX_ACTIVE || st_q == DRX_IDLE;

  // shared line: read data, wake-up pulse, else released
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      SERIAL_LINE_O    <= 1'b0;
      SERIAL_LINE_OE_O <= 1'b0;
      SERIAL_LINE_PU_O <= 1'b1;
    end
    else
    begin
      SERIAL_LINE_OE_O <= rd3_q | wake_drive;
      SERIAL_LINE_O    <= rd3_q & out_sh_q[7];
      SERIAL_LINE_PU_O <= 1'b1;
    end
  end

  // demod pins carry data, or serial read data in four-wire mode
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      FREQ_DEMOD_OUTPUT_O <= 1'b0;
      AMP_DEMOD_OUTPUT_O  <= 1'b0;
    end
    else
    begin
      if (rd4_q && regs_q[REG_CONFIG][CFG_FREQ_SEL_BIT])
        FREQ_DEMOD_OUTPUT_O <= out_sh_q[7];
      else
        FREQ_DEMOD_OUTPUT_O <= freq_s & demod_en;
      if (rd4_q && regs_q[REG_CONFIG][CFG_AMP_SEL_BIT])
        AMP_DEMOD_OUTPUT_O <= out_sh_q[7];
      else
        AMP_DEMOD_OUTPUT_O <= amp_s & demod_en;
    end
  end

  // module power, deep sleep and peak follow
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      POWER_EN_O        <= 8'h00;
      DEEP_SLEEP_O      <= 1'b1;
      PEAK_FOLLOW_O     <= 1'b0;
      CRYSTAL_DIVISOR_O <= 8'h00;
    end
    else
    begin
      DEEP_SLEEP_O <= sleep_bit
                    | (drx_en && (st_q == DRX_OFF || st_q == DRX_HOST));
      if (sleep_bit || (drx_en && (st_q == DRX_OFF || st_q == DRX_HOST)))
        POWER_EN_O <= 8'h00;
      else if (drx_en && st_q == DRX_SETTLE)
        POWER_EN_O <= regs_q[REG_POWER]
                    & ~(8'h01 << PWR_FREQ_PD_BIT)
                    & ~(8'h01 << PWR_AMP_PD_BIT);
      else
        POWER_EN_O <= regs_q[REG_POWER];
      PEAK_FOLLOW_O     <= follow;
      CRYSTAL_DIVISOR_O <= regs_q[REG_XTAL_DIV];
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  three_wire_a : assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    rd4_q |-> !SERIAL_LINE_OE_O || $past(rd3_q) || $past(wake_drive))
    else $error("shared line driven during four-wire read");
  read_drive_a : assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    rd3_q |=> SERIAL_LINE_OE_O)
    else $error("three-wire read does not drive the line");
  four_out_a : assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    rd4_q && regs_q[REG_CONFIG][CFG_AMP_SEL_BIT]
      |=> AMP_DEMOD_OUTPUT_O == $past(out_sh_q[7]))
    else $error("four-wire read data missing on output pin");
  frame_write_a : assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    wr_fire |-> bit_cnt_q == 5'd15 && frame.cmd == CMD_WRITE)
    else $error("write taken before full frame");
  mreset_hold_a : assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    mreset_q && cs_n_s |=> mreset_q)
    else $error("master reset released while select high");
  mreset_regs_a : assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    mreset_q |=> regs_q[REG_POWER] == RST_ZERO
                 && regs_q[REG_DWELL] == RST_DWELL)
    else $error("registers not at power-on value");
  nop_keep_a : assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    sclk_rise && bit_cnt_q == 5'd15 && frame.cmd != CMD_WRITE && !mreset_q
      |=> $stable(regs_q[REG_XTAL_DIV]))
    else $error("register changed by non-write command");
  sleep_force_a : assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    sleep_bit |=> POWER_EN_O == 8'h00 && DEEP_SLEEP_O)
    else $error("sleep bit did not force deep sleep");
  track_ctl_a : assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    regs_q[REG_CONTROL][CTL_TRACK_BIT] |=> PEAK_FOLLOW_O)
    else $error("peak follow not set by control bit");
  auto_track_a : assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    AGC_SWITCH_I |=> ##1 PEAK_FOLLOW_O [*8])
    else $error("gain switch did not pulse peak follow");
  wake_low_a : assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    $rose(st_q == DRX_HOST) |=> SERIAL_LINE_OE_O && !SERIAL_LINE_O)
    else $error("off interval end did not drive line low");
  restart_a : assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    st_q == DRX_SETTLE && done && !ack_q && line_s && drx_en && cs_n_s
      && !mreset_q |=> st_q == DRX_OFF)
    else $error("missing host answer did not restart sequence");
  settle_mute_a : assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    st_q == DRX_SETTLE && !rd4_q |=> !FREQ_DEMOD_OUTPUT_O)
    else $error("demod output active during settle");

endmodule : scdw_serial_ctrl
`default_nettype wire

//--- design/scdw_sync.sv
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser, one per bit
module scdw_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output var  logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : scdw_sync
`default_nettype wire

//--- verification/scdw_host.sv
`timescale 1ns/1ns
`default_nettype none
// host model: drives select, serial clock and its side of the shared line
module scdw_host (
  input  wire logic clk_i,
  input  wire logic line_i,
  input  wire logic fout_i,
  output var  logic sclk_o,
  output var  logic cs_n_o,
  output var  logic line_o,
  output var  logic line_oe_o
);
  // idle: deselected, clock still, line held low
  initial
  begin
    sclk_o    = 1'b0;
    cs_n_o    = 1'b1;
    line_o    = 1'b0;
    line_oe_o = 1'b1;
  end

  // one select cycle; n clocks, msb first, sample late in each high phase
  task automatic frame(input logic [15:0] w, input int n, input logic rd_cyc,
                       input logic four, output logic [15:0] rd);
    rd        = '0;
    line_oe_o = !rd_cyc;
    cs_n_o    = 1'b0;
    repeat (4) @(negedge clk_i);
    for (int i = 0; i < n; i++)
    begin
      sclk_o = 1'b0;
      line_o = w[15-i];
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b1;
      repeat (4) @(negedge clk_i);
      rd[15-i] = four ? fout_i : line_i;
    end
    sclk_o = 1'b0;
    repeat (4) @(negedge clk_i);
    cs_n_o    = 1'b1;
    line_oe_o = 1'b1;
    line_o    = 1'b0;
    repeat (8) @(negedge clk_i);
  endtask : frame

  // let go of the line so the pull-up raises it
  task automatic release_line();
    line_oe_o = 1'b0;
  endtask : release_line

  // answer a wake-up by pulling the line low
  task automatic ack_line();
    line_o    = 1'b0;
    line_oe_o = 1'b1;
  endtask : ack_line
endmodule : scdw_host
`default_nettype wire

//--- verification/tb_scdw_serial_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module tb_scdw_serial_ctrl;
  import scdw_pkg::*;
  logic clk = 0, rst = 1, sclk, cs_n, h_o, h_oe, d_o, d_oe, pu, line;
  logic fsl = 0, asl = 0, agc = 0, fout, aout, pk, slp;
  logic [7:0] pwr, div;
  logic [15:0] rd;
  int error_cnt = 0, comparisons = 0, cyc = 0;

  // ************************************************************
  // clock, wire resolution, instances
  // ************************************************************
  always #2 clk = !clk;
  assign line = d_oe ? d_o : (h_oe ? h_o : 1'b1);
  scdw_host host_i (.clk_i(clk), .line_i(line), .fout_i(fout),
    .sclk_o(sclk), .cs_n_o(cs_n), .line_o(h_o), .line_oe_o(h_oe));
  scdw_serial_ctrl scdw_serial_ctrl_i (.CORE_CLK_I(clk), .SYS_RST_I(rst),
    .SCLK_I(sclk), .CS_N_I(cs_n), .SERIAL_LINE_I(line),
    .SERIAL_LINE_O(d_o), .SERIAL_LINE_OE_O(d_oe), .SERIAL_LINE_PU_O(pu),
    .FREQ_SLICER_I(fsl), .AMP_SLICER_I(asl), .AGC_SWITCH_I(agc),
    .FREQ_DEMOD_OUTPUT_O(fout), .AMP_DEMOD_OUTPUT_O(aout),
    .PEAK_FOLLOW_O(pk), .DEEP_SLEEP_O(slp), .POWER_EN_O(pwr),
    .CRYSTAL_DIVISOR_O(div));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic check(input string nm, input logic [7:0] exp,
                       input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host_i.frame({CMD_WRITE, a, d}, 16, 1'b0, 1'b0, rd);
  endtask : wr

  task automatic rd3(input logic [3:0] a, input int n, output logic [7:0] v);
    host_i.frame({CMD_READ, a, 8'h00}, 8, 1'b0, 1'b0, rd);
    host_i.frame(16'h0000, n, 1'b1, 1'b0, rd);
    v = rd[15:8];
  endtask : rd3

  task automatic test_done();
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_regs();
    logic [7:0] v;
    check("div rst", 8'h00, div);
    check("sleep rst", 8'h00, {7'h0, slp});
    check("pullup", 8'h01, {7'h0, pu});
    wr(REG_XTAL_DIV, 8'h5f);
    check("div wr", 8'h5f, div);
    rd3(REG_XTAL_DIV, 8, v);
    check("rd8", 8'h5f, v);
    rd3(REG_XTAL_DIV, 16, v);
    check("rd16", 8'h5f, v);
    rd3(REG_DWELL, 8, v);
    check("dwell", 8'h0d, v);
    rd3(4'hb, 8, v);
    check("unmapped", 8'h00, v);
    host_i.frame({CMD_NOP, REG_XTAL_DIV, 8'hff}, 16, 1'b0, 1'b0, rd);
    host_i.frame({4'h7, REG_XTAL_DIV, 8'hff}, 16, 1'b0, 1'b0, rd);
    check("nop", 8'h5f, div);
    $display("test regs done");
  endtask : t_regs

  task automatic t_power();
    wr(REG_POWER, 8'h0c);
    check("awake", 8'h00, {7'h0, slp});
    check("pwr en", 8'h0c, pwr);
    wr(REG_POWER, 8'h0d);
    check("sleep", 8'h01, {7'h0, slp});
    $display("test power done");
  endtask : t_power

  task automatic t_track();
    wr(REG_CONTROL, 8'h02);
    check("trk on", 8'h01, {7'h0, pk});
    wr(REG_CONTROL, 8'h00);
    check("trk off", 8'h00, {7'h0, pk});
    agc = 1'b1;
    @(negedge clk);
    agc = 1'b0;
    repeat (3) @(negedge clk);
    check("agc trk", 8'h01, {7'h0, pk});
    repeat (600) @(negedge clk);
    check("agc end", 8'h00, {7'h0, pk});
    $display("test track done");
  endtask : t_track

  task automatic t_four();
    wr(REG_CONFIG, 8'hc0);
    wr(REG_XTAL_DIV, 8'ha5);
    host_i.frame({CMD_READ, REG_XTAL_DIV, 8'h00}, 16, 1'b0, 1'b1, rd);
    check("4w rd", 8'ha5, rd[7:0]);
    wr(REG_CONFIG, 8'h00);
    $display("test four done");
  endtask : t_four

  task automatic t_mreset();
    host_i.frame({CMD_MRESET, 4'h0, 8'h00}, 16, 1'b0, 1'b0, rd);
    check("mr div", 8'h00, div);
    check("mr pwr", 8'h00, {7'h0, slp});
    wr(REG_XTAL_DIV, 8'h33);
    check("after mr", 8'h33, div);
    $display("test mreset done");
  endtask : t_mreset

  task automatic t_drx();
    int k;
    wr(REG_POWER, 8'h00);
    wr(REG_OFF_LO, 8'h01);
    wr(REG_HOST_REC, 8'h02);
    wr(REG_RF_LO, 8'h01);
    wr(REG_CONFIG, 8'h44);
    fsl = 1'b1;
    asl = 1'b1;
    host_i.release_line();
    for (k = 0; k < 1000 && !(d_oe === 1'b1 && d_o === 1'b0); k++)
      @(negedge clk);
    check("wake low", 8'h00, {7'h0, line});
    host_i.ack_line();
    for (k = 0; k < 1500 && pk !== 1'b1; k++)
      @(negedge clk);
    check("wake trk", 8'h01, {7'h0, pk});
    repeat (300) @(negedge clk);
    check("demod on", 8'h01, {7'h0, fout});
    check("amp on", 8'h01, {7'h0, aout});
    host_i.release_line();
    repeat (20) @(negedge clk);
    for (k = 0; k < 1000 && !(d_oe === 1'b1 && d_o === 1'b0); k++)
      @(negedge clk);
    check("rewake", 8'h00, {7'h0, line});
    $display("test drx done");
  endtask : t_drx

  // ************************************************************
  // main sequence and timeout
  // ************************************************************
  initial
  begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_regs();
    t_power();
    t_track();
    t_four();
    t_mreset();
    t_drx();
    test_done();
  end

  // cycle ceiling against hangs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      test_done();
    end
  end
endmodule : tb_scdw_serial_ctrl
`default_nettype wire
